// file: sirc_pkg.sv
// Package for the serial interrupt and wait/ready control block.
// Holds register pointers, field positions, command codes, vector codes,
// reset values and the carrier structs shared by the channel and top-level modules.
package sirc_pkg;

   // Register pointer values carried in the command register
   localparam logic [2:0] PTR_CMD = 3'h0;
   localparam logic [2:0] PTR_IRQ_HS = 3'h1;
   localparam logic [2:0] PTR_VECTOR = 3'h2;
   localparam logic [2:0] PTR_RX_CTRL = 3'h3;

   // Command register fields
   localparam int CMD_PTR_LSB = 0;
   localparam int CMD_CODE_LSB = 3;
   localparam logic [2:0] CMD_RST_EXT = 3'h2;
   localparam logic [2:0] CMD_CHAN_RST = 3'h3;
   localparam logic [2:0] CMD_ARM_RX = 3'h4;
   localparam logic [2:0] CMD_RST_TX_PEND = 3'h5;
   localparam logic [2:0] CMD_ERR_RST = 3'h6;

   // Interrupt / handshake control register fields
   localparam int IH_EXT_EN = 0;
   localparam int IH_TX_EN = 1;
   localparam int IH_SAV = 2;
   localparam int IH_RXMODE_LSB = 3;
   localparam int IH_WR_ON_RX = 5;
   localparam int IH_WR_READY = 6;
   localparam int IH_WR_EN = 7;
   localparam logic [1:0] RXM_OFF = 2'h0;
   localparam logic [1:0] RXM_FIRST = 2'h1;
   localparam logic [1:0] RXM_ALL_PAR = 2'h2;

   // Receiver control register: receiver enable bit
   localparam int RC_RX_EN = 0;

   // Vector source codes; bit 3 marks channel A
   localparam logic [1:0] SRC_TX = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_RX = 2'h2;
   localparam logic [1:0] SRC_SP = 2'h3;
   localparam int VEC_SRC_LSB = 1;

   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [2:0] RST_PTR = 3'h0;

   // Number of synchronised bus pins: strobes, selects and data
   localparam int BUS_SYNC_W = 14;

   // Channel status from the receive/transmit logic (same clock)
   typedef struct packed {
      logic dcd;
      logic cts;
      logic sync_in;
      logic brk_abort;
      logic tx_underrun;
      logic tx_full;
      logic rx_full;
      logic rx_char;
      logic parity_err;
      logic overrun;
      logic framing_err;
      logic end_of_frame;
   } sirc_stat_t;

   // Pending interrupt sources of one channel
   typedef struct packed {
      logic sp;
      logic rx;
      logic tx;
      logic ext;
   } sirc_pend_t;

   // Per-channel strobes derived from the parallel bus
   typedef struct packed {
      logic clr_ext;
      logic clr_tx;
      logic arm_rx;
      logic err_rst;
      logic data_rd;
      logic data_wr;
      logic acc_self;
      logic acc_other;
      logic acc_any;
   } sirc_strb_t;

endpackage

// file: sirc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the pins change slowly compared with the system clock.
`timescale 1ns/1ps
`default_nettype none
module sirc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta <= INIT;
         o_q <= INIT;
      end else begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule
`default_nettype wire

// file: sirc_chan.sv
// One channel: interrupt pending latches and the wait/ready handshake.
// Assumes status inputs are on the system clock and bus strobes are
// already synchronised and reduced to one-cycle pulses or levels.
`timescale 1ns/1ps
`default_nettype none
module sirc_chan
   import sirc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_ih,
   input wire logic i_rx_en,
   input wire sirc_stat_t i_stat,
   input wire sirc_strb_t i_strb,
   output sirc_pend_t o_pend,
   output logic o_wrdy_o,
   output logic o_wrdy_oe
);
   sirc_stat_t stat_q;
   logic rx_armed;
   wire logic [1:0] rxm = i_ih[IH_RXMODE_LSB +: 2];
   wire logic rx_on = (rxm != RXM_OFF) && i_rx_en;
   wire logic ext_chg = (i_stat.dcd ^ stat_q.dcd) | (i_stat.cts ^ stat_q.cts)
      | (i_stat.sync_in ^ stat_q.sync_in)
      | (i_stat.brk_abort ^ stat_q.brk_abort)
      | (i_stat.tx_underrun & ~stat_q.tx_underrun);
   wire logic set_ext = i_ih[IH_EXT_EN] & ext_chg;
   wire logic set_tx = i_ih[IH_TX_EN] & stat_q.tx_full
      & ~i_stat.tx_full;
   wire logic sp_cond = i_stat.overrun | i_stat.framing_err
      | i_stat.end_of_frame
      | (i_stat.parity_err & (rxm == RXM_ALL_PAR));
   wire logic set_sp = rx_on & i_stat.rx_char & sp_cond;
   wire logic set_rx = rx_on & i_stat.rx_char & ~sp_cond
      & ((rxm != RXM_FIRST) | rx_armed);
   // Handshake direction: one buffer only, chosen by a single bit
   wire logic on_rx = i_ih[IH_WR_ON_RX];
   // Ready is active when a byte can move: rx full or tx empty
   wire logic buf_go = on_rx ? i_stat.rx_full : ~i_stat.tx_full;
   wire logic rdy_act = i_ih[IH_WR_EN] & buf_go & ~i_strb.acc_any;
   // Wait fires on a data access that would block, or an access elsewhere
   wire logic self_blk = i_strb.acc_self
      & (on_rx ? ~i_stat.rx_full : i_stat.tx_full);
   wire logic wait_act = i_ih[IH_WR_EN] & ~i_ih[IH_WR_READY]
      & (self_blk | i_strb.acc_other);
   // Disabled ready form still drives high; disabled wait form floats
   wire logic ready_mode = i_ih[IH_WR_READY];

   // Pending latches; a set in the same cycle as its clear wins
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_pend <= '0;
         stat_q <= '0;
         rx_armed <= 1'b1;
      end else begin
         stat_q <= i_stat;
         o_pend.ext <= set_ext | (o_pend.ext & ~i_strb.clr_ext);
         o_pend.tx <= set_tx
            | (o_pend.tx & ~i_strb.clr_tx & ~i_strb.data_wr);
         o_pend.rx <= set_rx | (o_pend.rx & ~i_strb.data_rd);
         o_pend.sp <= set_sp | (o_pend.sp & ~i_strb.err_rst);
         rx_armed <= i_strb.arm_rx
            | (rx_armed & ~(set_rx & (rxm == RXM_FIRST)));
      end
   end

   // Pin stage: ready drives both levels, wait only pulls low
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_wrdy_o <= 1'b1;
         o_wrdy_oe <= 1'b0;
      end else begin
         o_wrdy_o <= ready_mode ? ~rdy_act : 1'b0;
         o_wrdy_oe <= ready_mode | wait_act;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_tx_empty_int;
      i_ih[IH_TX_EN] && $fell(i_stat.tx_full) |=> o_pend.tx;
   endproperty
   a_tx_empty_int: assert property (p_tx_empty_int)
      else $error("tx empty did not latch interrupt");

   property p_rdy_off;
      (i_ih[IH_WR_EN] && i_ih[IH_WR_READY] && i_strb.acc_any)
         |=> o_wrdy_o && o_wrdy_oe;
   endproperty
   a_rdy_off: assert property (p_rdy_off)
      else $error("ready stayed active during a bus access");

   property p_wait_float;
      (i_ih[IH_WR_EN] && !i_ih[IH_WR_READY] && !i_strb.acc_self
         && !i_strb.acc_other) |=> !o_wrdy_oe;
   endproperty
   a_wait_float: assert property (p_wait_float)
      else $error("wait driven without an access");

   property p_disabled_high;
      (!i_ih[IH_WR_EN] && i_ih[IH_WR_READY]) [*2] |-> o_wrdy_o && o_wrdy_oe;
   endproperty
   a_disabled_high: assert property (p_disabled_high)
      else $error("handshake not high while disabled");

   property p_disabled_float;
      (!i_ih[IH_WR_EN] && !i_ih[IH_WR_READY]) [*2] |-> !o_wrdy_oe;
   endproperty
   a_disabled_float: assert property (p_disabled_float)
      else $error("wait form driven while disabled");

   c_wait_low: cover property (o_wrdy_oe && !o_wrdy_o && !ready_mode);
   c_sp_int: cover property (set_sp);
endmodule
`default_nettype wire

// file: sirc_top.sv
// Interrupt and wait/ready control for a dual-channel serial controller.
// Assumes an asynchronous parallel bus whose strobes stay stable for
// several system clocks, and status from the channel logic on I_MCLK.
//
// Operation
// - External/status enable: line, break and underrun changes interrupt.
// - Transmit enable: interrupt each time the transmit buffer empties.
// - Status-affects-vector only counts from channel B's control register.
// - Status-affects-vector clear: acknowledge returns the written vector.
// - With it, vector bits 3..1 give source; channel A adds four.
// - Parity, overrun, framing, end-of-frame: special receive conditions.
// - Receive mode picks none, first char, all with or without parity.
// - Nonzero receive mode: special conditions interrupt with own code.
// - Handshake works only when enabled; else ready high, wait floating.
// - Function bit picks wait at 0 and ready at 1.
// - Wait is open drain: floats inactive, pulls low active.
// - Ready goes from high to low when a byte can move.
// - Direction bit: 1 follows receive buffer, 0 transmit buffer.
// - Handshake serves one direction at a time only.
// - Transmit: ready low on empty; wait low on full when addressed.
// - Receive: ready low on full; wait low on empty when addressed.
// - Ready may fire unselected and drops on any selected bus access.
// - Wait fires on reading absent data or writing a full buffer.
// - A channel's wait also fires when the other channel is addressed.
// - Vector register lives in channel B; bits 3..1 altered only by mode.
// - Command pointer picks next register, then returns to command.
`timescale 1ns/1ps
`default_nettype none
module sirc_top
   import sirc_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_RSTN,
   input wire logic I_IO_REQUEST_N,
   input wire logic I_CS_N,
   input wire logic I_RD_N,
   input wire logic I_M1_N,
   input wire logic I_CHAN_B,
   input wire logic I_CTRL,
   input wire logic [7:0] I_D,
   input wire sirc_stat_t I_STAT_A,
   input wire sirc_stat_t I_STAT_B,
   output logic [7:0] O_D,
   output logic O_D_OE,
   output logic O_INT_N,
   output logic O_WRDY_A_O,
   output logic O_WRDY_A_OE,
   output logic O_WRDY_B_O,
   output logic O_WRDY_B_OE
);
   logic [BUS_SYNC_W-1:0] pins_s;
   logic [2:0] ptr [2];
   logic [7:0] ih [2];
   logic [7:0] rxc [2];
   logic [7:0] vec;
   logic acc_q;
   logic [1:0] chan_rst;
   sirc_pend_t pend [2];
   sirc_strb_t strb [2];
   logic [1:0] wrdy_o;
   logic [1:0] wrdy_oe;

   // Bus pins come from another timing domain, so they pass two flops
   sirc_sync #(.W(BUS_SYNC_W), .INIT(14'h3f00)) u_sync (
      .i_clk(I_MCLK),
      .i_rst_n(I_RSTN),
      .i_d({I_IO_REQUEST_N, I_CS_N, I_RD_N, I_M1_N, I_CHAN_B, I_CTRL,
            I_D}),
      .o_q(pins_s)
   );

   // Decoded bus signals; index 1 is channel B, index 0 channel A
   wire logic io_request_n_n_s = pins_s[13];
   wire logic cs_n_s = pins_s[12];
   wire logic rd_n_s = pins_s[11];
   wire logic m1_n_s = pins_s[10];
   wire logic chb_s = pins_s[9];
   wire logic ctrl_s = pins_s[8];
   wire logic [7:0] d_s = pins_s[7:0];
   wire logic acc = ~io_request_n_n_s & ~cs_n_s & m1_n_s;
   wire logic acc_start = acc & ~acc_q;
   wire logic int_ack = ~io_request_n_n_s & ~m1_n_s;
   wire logic wr_start = acc_start & rd_n_s;
   wire logic rd_start = acc_start & ~rd_n_s;
   wire logic [2:0] cmd_code = d_s[CMD_CODE_LSB +: 3];

   // Vector source: channel A outranks B; special, receive, transmit, ext
   wire logic sel_a = |pend[0];
   wire sirc_pend_t pv = sel_a ? pend[0] : pend[1];
   wire logic [1:0] src = pv.sp ? SRC_SP : pv.rx ? SRC_RX
      : pv.tx ? SRC_TX : SRC_EXT;
   wire logic sav = ih[1][IH_SAV];
   wire logic [7:0] vec_out = sav
      ? {vec[7:4], sel_a, src, vec[0]} : vec;
   wire logic any_pend = |pend[0] | |pend[1];

   // Access edge detector on the synchronised strobes
   always_ff @(posedge I_MCLK) begin
      if (!I_RSTN) begin
         acc_q <= 1'b0;
      end else begin
         acc_q <= acc;
      end
   end

   // Per-channel register file, pointer and command strobes
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         wire logic me = (chb_s == 1'(ch));
         wire logic ctl_wr = wr_start & ctrl_s & me;
         wire logic ctl_rd = rd_start & ctrl_s & me;
         wire logic to_cmd = ctl_wr & (ptr[ch] == PTR_CMD);
         wire logic cmd_hit = to_cmd & ~chan_rst[ch];
         wire logic rst_n = I_RSTN & ~chan_rst[ch];

         // Pointer goes back to the command register after any other access
         always_ff @(posedge I_MCLK) begin
            if (!rst_n) begin
               ptr[ch] <= RST_PTR;
               ih[ch] <= RST_REG;
               rxc[ch] <= RST_REG;
            end else if (to_cmd) begin
               ptr[ch] <= d_s[CMD_PTR_LSB +: 3];
            end else if (ctl_wr | ctl_rd) begin
               ptr[ch] <= PTR_CMD;
               if (ctl_wr && ptr[ch] == PTR_IRQ_HS) begin
                  ih[ch] <= d_s;
               end
               if (ctl_wr && ptr[ch] == PTR_RX_CTRL) begin
                  rxc[ch] <= d_s;
               end
            end
         end

         // Channel reset is held one cycle so the channel clears fully
         always_ff @(posedge I_MCLK) begin
            if (!I_RSTN) begin
               chan_rst[ch] <= 1'b0;
            end else begin
               chan_rst[ch] <= to_cmd & (cmd_code == CMD_CHAN_RST)
                  & ~chan_rst[ch];
            end
         end

         assign strb[ch].clr_ext = cmd_hit & (cmd_code == CMD_RST_EXT);
         assign strb[ch].clr_tx = cmd_hit & (cmd_code == CMD_RST_TX_PEND);
         assign strb[ch].arm_rx = cmd_hit & (cmd_code == CMD_ARM_RX);
         assign strb[ch].err_rst = cmd_hit & (cmd_code == CMD_ERR_RST);
         assign strb[ch].data_rd = rd_start & ~ctrl_s & me;
         assign strb[ch].data_wr = wr_start & ~ctrl_s & me;
         // Rx handshake blocks on reads, tx handshake on writes
         assign strb[ch].acc_self = acc & ~ctrl_s & me
            & (ih[ch][IH_WR_ON_RX] ? ~rd_n_s : rd_n_s);
         assign strb[ch].acc_other = acc & ~me;
         assign strb[ch].acc_any = acc;

         sirc_chan u_chan (
            .i_clk(I_MCLK),
            .i_rst_n(rst_n),
            .i_ih(ih[ch]),
            .i_rx_en(rxc[ch][RC_RX_EN]),
            .i_stat(ch == 0 ? I_STAT_A : I_STAT_B),
            .i_strb(strb[ch]),
            .o_pend(pend[ch]),
            .o_wrdy_o(wrdy_o[ch]),
            .o_wrdy_oe(wrdy_oe[ch])
         );
      end
   endgenerate

   // Vector register exists in channel B only
   always_ff @(posedge I_MCLK) begin
      if (!I_RSTN) begin
         vec <= RST_REG;
      end else if (wr_start && ctrl_s && chb_s && ptr[1] == PTR_VECTOR
                   && !chan_rst[1]) begin
         vec <= d_s;
      end
   end

   // Output stage; the data bus is driven only during acknowledge
   always_ff @(posedge I_MCLK) begin
      if (!I_RSTN) begin
         O_D <= RST_REG;
         O_D_OE <= 1'b0;
         O_INT_N <= 1'b1;
      end else begin
         O_D <= vec_out;
         O_D_OE <= int_ack;
         O_INT_N <= ~any_pend;
      end
   end

   assign O_WRDY_A_O = wrdy_o[0];
   assign O_WRDY_A_OE = wrdy_oe[0];
   assign O_WRDY_B_O = wrdy_o[1];
   assign O_WRDY_B_OE = wrdy_oe[1];

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RSTN);

   property p_fixed_vec;
      !sav && int_ack |=> O_D_OE && O_D == $past(vec);
   endproperty
   a_fixed_vec: assert property (p_fixed_vec)
      else $error("fixed vector altered");

   property p_var_vec;
      sav && int_ack && pend[0].tx && !pend[0].rx && !pend[0].sp
         |=> O_D[3:1] == 3'h4 && O_D[7:4] == $past(vec[7:4]);
   endproperty
   a_var_vec: assert property (p_var_vec)
      else $error("channel A tx vector code wrong");

   property p_sav_a_ignored;
      !ih[1][IH_SAV] && ih[0][IH_SAV] && int_ack |=> O_D == $past(vec);
   endproperty
   a_sav_a_ignored: assert property (p_sav_a_ignored)
      else $error("channel A status bit changed the vector");

   property p_ptr_return;
      wr_start && ctrl_s && chb_s && ptr[1] != PTR_CMD && !chan_rst[1]
         |=> ptr[1] == PTR_CMD;
   endproperty
   a_ptr_return: assert property (p_ptr_return)
      else $error("pointer did not return to command register");

   property p_int_line;
      any_pend |=> !O_INT_N;
   endproperty
   a_int_line: assert property (p_int_line)
      else $error("interrupt output missed a pending source");

   c_vec_read: cover property (int_ack && sav ##1 O_D_OE);
   c_vec_write: cover property (wr_start && ptr[1] == PTR_VECTOR);
   c_chan_reset: cover property (chan_rst[0]);
endmodule
`default_nettype wire

// file: sirc_host.sv
// Behavioural host: processor and DMA controller on the parallel bus.
// Assumes the device samples the bus pins on i_clk through a synchroniser.
`timescale 1ns/1ps
`default_nettype none
module sirc_host (
   input wire logic i_clk,
   input wire logic i_wrdy_a_o,
   input wire logic i_wrdy_a_oe,
   input wire logic i_wrdy_b_o,
   input wire logic i_wrdy_b_oe,
   input wire logic i_d_oe,
   input wire logic [7:0] i_d,
   output logic o_io_request_n,
   output logic o_cs_n,
   output logic o_rd_n,
   output logic o_m1_n,
   output logic o_chan_b,
   output logic o_ctrl,
   output logic [7:0] o_d,
   output logic o_lvl_a,
   output logic o_lvl_b
);
   // Handshake pins carry a pull-up, so a released pin reads high
   assign o_lvl_a = i_wrdy_a_oe ? i_wrdy_a_o : 1'b1;
   assign o_lvl_b = i_wrdy_b_oe ? i_wrdy_b_o : 1'b1;

   // Bus idle at time zero
   initial begin
      o_io_request_n = 1'b1;
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_m1_n = 1'b1;
      o_chan_b = 1'b0;
      o_ctrl = 1'b0;
      o_d = 8'h00;
   end

   // One bus cycle, held long enough to cross the synchroniser
   task automatic access(input logic ch, input logic ctl, input logic rd,
         input logic [7:0] dat, output logic [1:0] lvl);
      @(posedge i_clk);
      #1;
      o_chan_b = ch;
      o_ctrl = ctl;
      o_rd_n = ~rd;
      o_d = dat;
      o_io_request_n = 1'b0;
      o_cs_n = 1'b0;
      repeat (5) @(posedge i_clk);
      #1;
      lvl = {o_lvl_a, o_lvl_b};
      o_io_request_n = 1'b1;
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_d = ~dat; // Released lines must not keep the old value
      repeat (4) @(posedge i_clk);
      #1;
   endtask

   // Pointer byte, then the pointed register
   task automatic wreg(input logic ch, input logic [2:0] ptr,
         input logic [7:0] val);
      logic [1:0] l;
      access(ch, 1'b1, 1'b0, {5'h00, ptr}, l);
      access(ch, 1'b1, 1'b0, val, l);
   endtask

   // Interrupt acknowledge; gives unknown if the vector never appears
   task automatic ack(output logic [7:0] vec);
      int n;
      @(posedge i_clk);
      #1;
      o_io_request_n = 1'b0;
      o_m1_n = 1'b0;
      for (n = 0; n < 10 && i_d_oe !== 1'b1; n++) begin
         @(posedge i_clk);
         #1;
      end
      vec = (i_d_oe === 1'b1) ? i_d : 8'hxx;
      o_io_request_n = 1'b1;
      o_m1_n = 1'b1;
      repeat (6) @(posedge i_clk);
      #1;
   endtask

   // DMA: waits for ready low, then moves one byte to the data port
   task automatic dma_write(input logic ch, input logic [7:0] dat,
         output logic [1:0] lvl);
      int n;
      // Pin level is looked at after it settles, not at the launching edge
      for (n = 0; n < 20 && (ch ? o_lvl_b : o_lvl_a) !== 1'b0; n++) begin
         @(posedge i_clk);
         #1;
      end
      access(ch, 1'b0, 1'b0, dat, lvl);
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the interrupt and wait/ready control block.
// Assumes sirc_host plays the processor and DMA side of the bus.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import sirc_pkg::*;
;
   typedef struct packed {
      logic ch;
      logic [1:0] kind;
      logic [7:0] vec;
   } sirc_row_t;

   logic clk = 1'b0;
   logic rstn = 1'b0;
   sirc_stat_t sa, sb;
   logic io_n, cs_n, rd_n, m1_n, chan_b, ctrl, d_oe, int_n;
   logic wa_o, wa_oe, wb_o, wb_oe, lvl_a, lvl_b;
   logic [7:0] d_in, d_out, v;
   logic [1:0] l;
   int fail_count = 0;
   int checks_done = 0;
   // Source per channel with status-affects-vector on, vector written a5
   sirc_row_t rows [8] = '{'{1'b1, 2'h0, 8'ha1}, '{1'b1, 2'h1, 8'ha3},
      '{1'b1, 2'h2, 8'ha5}, '{1'b1, 2'h3, 8'ha7}, '{1'b0, 2'h0, 8'ha9},
      '{1'b0, 2'h1, 8'hab}, '{1'b0, 2'h2, 8'had}, '{1'b0, 2'h3, 8'haf}};

   always #2 clk = ~clk;

   sirc_top dut (.I_MCLK(clk), .I_RSTN(rstn), .I_IO_REQUEST_N(io_n),
      .I_CS_N(cs_n), .I_RD_N(rd_n), .I_M1_N(m1_n), .I_CHAN_B(chan_b),
      .I_CTRL(ctrl), .I_D(d_in), .I_STAT_A(sa), .I_STAT_B(sb),
      .O_D(d_out), .O_D_OE(d_oe), .O_INT_N(int_n), .O_WRDY_A_O(wa_o),
      .O_WRDY_A_OE(wa_oe), .O_WRDY_B_O(wb_o), .O_WRDY_B_OE(wb_oe));

   sirc_host host (.i_clk(clk), .i_wrdy_a_o(wa_o), .i_wrdy_a_oe(wa_oe),
      .i_wrdy_b_o(wb_o), .i_wrdy_b_oe(wb_oe), .i_d_oe(d_oe), .i_d(d_out),
      .o_io_request_n(io_n), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_m1_n(m1_n),
      .o_chan_b(chan_b), .o_ctrl(ctrl), .o_d(d_in), .o_lvl_a(lvl_a),
      .o_lvl_b(lvl_b));

   task automatic chk8(input string nm, input logic [7:0] e,
         input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", nm, e, s);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Status event: 0 tx empties, 1 carrier edge, 2 char, 3 char with parity
   task automatic ev(input logic ch, input logic [1:0] k);
      sirc_stat_t s;
      tick(1);
      s = ch ? sb : sa;
      case (k)
         2'h0: s.tx_full = 1'b0;
         2'h1: s.dcd = ~s.dcd;
         2'h2: s.rx_char = 1'b1;
         default: begin
            s.rx_char = 1'b1;
            s.parity_err = 1'b1;
         end
      endcase
      if (ch) sb = s;
      else sa = s;
      tick(1);
      {sa.rx_char, sa.parity_err, sb.rx_char, sb.parity_err} = 4'h0;
   endtask

   // Clears the source with its own command or data access
   task automatic clr(input logic ch, input logic [1:0] k);
      case (k)
         2'h0: host.access(ch, 1'b1, 1'b0, {2'h0, CMD_RST_TX_PEND, 3'h0}, l);
         2'h1: host.access(ch, 1'b1, 1'b0, {2'h0, CMD_RST_EXT, 3'h0}, l);
         2'h2: host.access(ch, 1'b0, 1'b1, 8'h00, l);
         default: host.access(ch, 1'b1, 1'b0, {2'h0, CMD_ERR_RST, 3'h0}, l);
      endcase
   endtask

   // Cuts a hang short; the whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      give_verdict();
   end

   initial begin
      sa = '0;
      sb = '0;
      sa.tx_full = 1'b1;
      sb.tx_full = 1'b1;
      tick(6);
      chk1("int_n in reset", 1'b1, int_n);
      chk1("d_oe in reset", 1'b0, d_oe);
      tick(6);
      rstn = 1'b1;
      tick(3);
      chk1("disabled pin level", 1'b1, lvl_b);
      chk1("disabled wait floats", 1'b0, wb_oe);
      host.wreg(1'b1, PTR_VECTOR, 8'ha5);
      host.wreg(1'b1, PTR_IRQ_HS, 8'h17);
      host.wreg(1'b0, PTR_IRQ_HS, 8'h17);
      host.wreg(1'b0, PTR_RX_CTRL, 8'h01);
      host.wreg(1'b1, PTR_RX_CTRL, 8'h01);
      foreach (rows[i]) begin
         ev(rows[i].ch, rows[i].kind);
         tick(3);
         chk1("int_n raised", 1'b0, int_n);
         host.ack(v);
         chk8("vector", rows[i].vec, v);
         clr(rows[i].ch, rows[i].kind);
         chk1("int_n cleared", 1'b1, int_n);
      end
      // Receive mode off: neither chars nor special conditions interrupt
      host.wreg(1'b1, PTR_IRQ_HS, 8'h07);
      ev(1'b1, 2'h2);
      ev(1'b1, 2'h3);
      tick(3);
      chk1("int_n mode off", 1'b1, int_n);
      // Parity not special in mode 11
      host.wreg(1'b1, PTR_IRQ_HS, 8'h1c);
      ev(1'b1, 2'h3);
      tick(3);
      host.ack(v);
      chk8("vector mode 11", 8'ha5, v);
      clr(1'b1, 2'h2);
      // Status bit clear in B, set in A: vector comes back unchanged
      host.wreg(1'b1, PTR_IRQ_HS, 8'h13);
      ev(1'b0, 2'h1);
      tick(3);
      host.ack(v);
      chk8("fixed vector", 8'ha5, v);
      clr(1'b0, 2'h1);
      // First-character mode: one interrupt, then none until re-armed
      host.wreg(1'b1, PTR_IRQ_HS, 8'h0c);
      ev(1'b1, 2'h2);
      tick(3);
      chk1("first char int", 1'b0, int_n);
      clr(1'b1, 2'h2);
      ev(1'b1, 2'h2);
      tick(3);
      chk1("second char quiet", 1'b1, int_n);
      host.access(1'b1, 1'b1, 1'b0, {2'h0, CMD_ARM_RX, 3'h0}, l);
      ev(1'b1, 2'h2);
      tick(3);
      host.ack(v);
      chk8("re-armed char", 8'ha5, v);
      clr(1'b1, 2'h2);
      // Channel reset clears the enables; next byte goes to command
      host.wreg(1'b1, PTR_IRQ_HS, 8'h01);
      host.access(1'b1, 1'b1, 1'b0, {2'h0, CMD_CHAN_RST, 3'h0}, l);
      ev(1'b1, 2'h1);
      tick(3);
      chk1("chan reset int off", 1'b1, int_n);
      // Ready on transmit, then a DMA byte move
      sb.tx_full = 1'b1;
      host.wreg(1'b1, PTR_IRQ_HS, 8'hc0);
      tick(4);
      chk1("ready tx full", 1'b1, lvl_b);
      sb.tx_full = 1'b0;
      tick(4);
      chk1("ready tx empty", 1'b0, lvl_b);
      sb.rx_full = 1'b1;
      tick(4);
      chk1("ready ignores rx", 1'b0, lvl_b);
      host.dma_write(1'b1, 8'h55, l);
      chk1("ready in access", 1'b1, l[0]);
      // Wait on receive, open drain
      sb.rx_full = 1'b0;
      host.wreg(1'b1, PTR_IRQ_HS, 8'ha0);
      tick(4);
      chk1("wait idle floats", 1'b0, wb_oe);
      host.access(1'b1, 1'b0, 1'b1, 8'h00, l);
      chk1("wait rx empty", 1'b0, l[0]);
      sb.rx_full = 1'b1;
      host.access(1'b1, 1'b0, 1'b1, 8'h00, l);
      chk1("wait rx full", 1'b1, l[0]);
      host.access(1'b0, 1'b1, 1'b0, 8'h00, l);
      chk1("wait other chan", 1'b0, l[0]);
      host.wreg(1'b1, PTR_IRQ_HS, 8'h00);
      tick(4);
      chk1("wait off floats", 1'b0, wb_oe);
      // Channel A ready form while disabled is driven high
      host.wreg(1'b0, PTR_IRQ_HS, 8'h40);
      tick(4);
      chk1("A disabled high", 1'b1, wa_o);
      chk1("A disabled driven", 1'b1, wa_oe);
      give_verdict();
   end
endmodule
`default_nettype wire
